// >>> verilog/mcbus_unit.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mcbus_defs.svh"
module mcbus_unit
	import mcbus_pkg::*;
#(
	parameter int PADDR_W = 12
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               system_reference_clock,
	input  wire logic [31:0]        ad_in,
	output logic      [31:0]        ad_out,
	output logic                    ad_oe_n,
	output logic                    bus_oe_n,
	output logic                    ale,
	output logic      [3:0]         addr_lo,
	output logic                    diag,
	output logic                    rd_n,
	output logic                    wr_n,
	output logic                    burst_near_n,
	output logic                    mem_drive_enable_n,
	input  wire logic               ack_n,
	input  wire logic               read_capture_enable_n,
	input  wire logic               master_request_n,
	output logic                    master_grant_n,
	input  wire logic               pin3_in,
	output logic                    io_pulse_n,
	output logic                    pin3_oe_n,
	input  wire logic               pin2_in,
	output logic                    extended_drive_enable_n,
	output logic                    pin2_oe_n,
	output logic                    memory_pulse_n
);

	if (PADDR_W < 6) begin : g_chk
		$error("PADDR_W too small for the register map");
	end
	function automatic logic [4:0] piece_bytes(input logic [1:0] pw);
		piece_bytes = (pw == `PW_32) ? 5'h4 : (pw == `PW_16) ? 5'h2 : 5'h1;
	endfunction
	function automatic logic [31:0] place(input logic [31:0] w,
	                                      input logic [3:0] lo,
	                                      input logic [1:0] pw);
		place = (pw == `PW_32) ? w : (w >> {lo[1:0], 3'h0});
	endfunction
	// Synchronisers and link edge detect
	pins_s       s1_q;
	pins_s       s2_q;
	logic        clk_prev_q;
	logic [31:0] ad1_q;
	logic [31:0] ad2_q;
	pins_s       raw_w;
	assign raw_w = '{clk: system_reference_clock, ack_n: ack_n,
		cap_n: read_capture_enable_n, req_n: master_request_n,
		c3: pin3_in, c2: pin2_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q       <= '{default: 1'b1};
			s2_q       <= '{default: 1'b1};
			clk_prev_q <= 1'b1;
			ad1_q      <= 32'h0;
			ad2_q      <= 32'h0;
		end else begin
			s1_q       <= raw_w;
			s2_q       <= s1_q;
			clk_prev_q <= s2_q.clk;
			ad1_q      <= ad_in;
			ad2_q      <= ad1_q;
		end
	end
	wire rise_w = s2_q.clk & ~clk_prev_q;
	wire fall_w = ~s2_q.clk & clk_prev_q;
	wire ack_w  = ~s2_q.ack_n;
	wire cap_w  = ~s2_q.cap_n;
	wire req_w  = ~s2_q.req_n;
	// Register file
	ctrl_s       ctrl_q;
	cmd_s        cmd_q;
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic        go_q;
	logic [31:0] rbuf_q [4];
	bus_state_e  st_q;
	logic [4:0]  left_q;
	logic        wr_x_q;
	logic        ack_seen_q;
	logic        capd_q;
	logic        prev_wr_q;
	logic [23:0] page_q;
	wire [11:0] off_w    = 12'(paddr);
	wire        setup_w  = psel & ~penable;
	wire        wr_acc_w = psel & penable & pwrite;
	wire        busy_w   = go_q | (st_q != ST_IDLE);
	wire        rd_hit_w = (off_w >= `OFF_RDATA0) &&
		(off_w <= `OFF_RDATA3) && (off_w[1:0] == 2'h0);
	wire [1:0]  rd_idx_w = 2'(off_w - `OFF_RDATA0 >> 2);
	wire        map_w = (off_w == `OFF_CTRL) || (off_w == `OFF_ADDR) ||
		(off_w == `OFF_WDATA) || (off_w == `OFF_CMD) ||
		(off_w == `OFF_STATUS) || rd_hit_w;
	wire [1:0]  cond_w = {s2_q.c3 & ~ctrl_q.pin3_io,
		s2_q.c2 & ~ctrl_q.pin2_ext};
	wire [31:0] status_w = {20'h0, cond_w, ~master_grant_n, ack_seen_q,
		left_q, st_q};
	wire [31:0] rmux_w =
		(off_w == `OFF_CTRL)   ? {18'h0, ctrl_q} :
		(off_w == `OFF_ADDR)   ? addr_q :
		(off_w == `OFF_WDATA)  ? wdata_q :
		(off_w == `OFF_CMD)    ? {23'h0, cmd_q} :
		(off_w == `OFF_STATUS) ? status_w :
		rd_hit_w ? rbuf_q[rd_idx_w] : 32'h0;
	wire        start_w = rise_w & (st_q == ST_IDLE) & go_q & ~req_w;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup_w) begin
				prdata  <= rmux_w;
				pslverr <= ~map_w;
			end
		end
	end

	// Transfer registers refused while a transaction is pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= `CTRL_RST;
			cmd_q   <= `CMD_RST;
			addr_q  <= 32'h0;
			wdata_q <= 32'h0;
			go_q    <= 1'b0;
		end else begin
			if (wr_acc_w && off_w == `OFF_CTRL)
				ctrl_q <= ctrl_s'(pwdata[`CTRL_W-1:0]);
			if (wr_acc_w && !busy_w && off_w == `OFF_ADDR)
				addr_q <= pwdata;
			if (wr_acc_w && !busy_w && off_w == `OFF_WDATA)
				wdata_q <= pwdata;
			if (wr_acc_w && !busy_w && off_w == `OFF_CMD) begin
				cmd_q <= cmd_s'(pwdata[`CMD_W-1:0]);
				go_q  <= 1'b1;
			end else if (start_w) begin
				go_q <= 1'b0;
			end
		end
	end

	// Transaction decode
	wire [1:0]  pw_w     = ctrl_q.port_w;
	wire [4:0]  pb_w     = piece_bytes(pw_w);
	wire        burst_w  = ~cmd_q.write & cmd_q.miss &
		(cmd_q.instr | ctrl_q.dburst) & (cmd_q.size == SZ_QUAD);
	wire        near_w   = cmd_q.write & prev_wr_q &
		(page_q == addr_q[31:8]);
	wire [4:0]  bytes_w  = burst_w ? `BLOCK_BYTES :
		(cmd_q.size == SZ_BYTE) ? 5'h1 :
		(cmd_q.size == SZ_HALF) ? 5'h2 : 5'h4;
	wire [4:0]  npc_w    = (bytes_w > pb_w) ? (bytes_w >> (2'h2 - pw_w)) :
		5'h1;
	wire [3:0]  lo_w     = burst_w ? 4'h0 : cmd_q.lo;
	wire [3:0]  lane_w   = (cmd_q.size == SZ_BYTE) ?
		4'(4'h1 << cmd_q.lo[1:0]) :
		(cmd_q.size == SZ_HALF) ? (cmd_q.lo[1] ? 4'hc : 4'h3) : 4'hf;
	wire [3:0]  be_n_w   = (!cmd_q.write && ctrl_q.be_rdmask) ? 4'hf :
		~lane_w;
	wire        piece_w  = wr_x_q ? ack_w : (cap_w | capd_q);
	wire        done_w   = piece_w & (wr_x_q | (left_q != 5'h0) |
		ack_w | ack_seen_q);
	wire [3:0]  next_lo_w = 4'(addr_lo + pb_w[3:0]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q           <= ST_IDLE;
			ale            <= 1'b0;
			ad_out         <= 32'h0;
			ad_oe_n        <= 1'b1;
			bus_oe_n       <= 1'b0;
			addr_lo        <= 4'h0;
			diag           <= 1'b0;
			rd_n           <= 1'b1;
			wr_n           <= 1'b1;
			burst_near_n   <= 1'b1;
			master_grant_n <= 1'b1;
			left_q         <= 5'h0;
			wr_x_q         <= 1'b0;
			prev_wr_q      <= 1'b0;
			page_q         <= 24'h0;
		end else if (rise_w) begin
			case (st_q)
			ST_IDLE: begin
				if (req_w) begin
					st_q           <= ST_GRANT;
					master_grant_n <= 1'b0;
					bus_oe_n       <= 1'b1;
					ad_oe_n        <= 1'b1;
				end else if (go_q) begin
					st_q         <= ST_ADDR;
					ale          <= 1'b1;
					ad_out       <= {addr_q[31:4], be_n_w};
					ad_oe_n      <= 1'b0;
					addr_lo      <= lo_w;
					diag         <= cmd_q.miss;
					rd_n         <= cmd_q.write;
					wr_n         <= ~cmd_q.write;
					burst_near_n <= ~(burst_w | near_w);
					left_q       <= 5'(npc_w - 5'h1);
					wr_x_q       <= cmd_q.write;
				end
			end
			ST_ADDR: begin
				st_q <= ST_DATA;
				ale  <= 1'b0;
				diag <= cmd_q.instr;
				if (wr_x_q)
					ad_out <= place(wdata_q, addr_lo, pw_w);
				else
					ad_oe_n <= 1'b1;
			end
			ST_DATA: begin
				if (done_w && left_q == 5'h0) begin
					st_q         <= ST_TURN;
					rd_n         <= 1'b1;
					wr_n         <= 1'b1;
					burst_near_n <= 1'b1;
					ad_oe_n      <= 1'b1;
				end else if (done_w) begin
					st_q    <= ST_GAP;
					left_q  <= left_q - 5'h1;
					addr_lo <= next_lo_w;
				end
			end
			ST_GAP: begin
				st_q <= ST_DATA;
				if (wr_x_q)
					ad_out <= place(wdata_q, addr_lo, pw_w);
			end
			ST_TURN: begin
				st_q      <= ST_IDLE;
				prev_wr_q <= wr_x_q;
				page_q    <= addr_q[31:8];
			end
			ST_GRANT: begin
				if (!req_w) begin
					st_q           <= ST_IDLE;
					master_grant_n <= 1'b1;
					bus_oe_n       <= 1'b0;
					prev_wr_q      <= 1'b0;
				end else if (ctrl_q.early_gnt && ctrl_q.reclaim) begin
					st_q           <= ST_RECLAIM;
					master_grant_n <= 1'b1;
				end
			end
			ST_RECLAIM: begin
				if (!req_w) begin
					st_q      <= ST_IDLE;
					bus_oe_n  <= 1'b0;
					prev_wr_q <= 1'b0;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Per-piece capture and acknowledge bookkeeping
	wire        in_data_w = (st_q == ST_DATA);
	wire        take_w    = in_data_w & ~wr_x_q & cap_w & ~capd_q;
	wire [1:0]  widx_w    = addr_lo[3:2];
	wire [31:0] old_w     = rbuf_q[widx_w];
	wire [31:0] merged_w  =
		(pw_w == `PW_32) ? ad2_q :
		(pw_w == `PW_16) ? (addr_lo[1] ? {ad2_q[15:0], old_w[15:0]} :
			{old_w[31:16], ad2_q[15:0]}) :
		((old_w & ~(32'h0000_00ff << {addr_lo[1:0], 3'h0})) |
			({24'h0, ad2_q[7:0]} << {addr_lo[1:0], 3'h0}));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rbuf_q     <= '{default: 32'h0};
			capd_q     <= 1'b0;
			ack_seen_q <= 1'b0;
		end else begin
			if (take_w)
				rbuf_q[widx_w] <= merged_w;
			if (st_q == ST_ADDR || (rise_w && st_q == ST_DATA && done_w))
				capd_q <= 1'b0;
			else if (take_w)
				capd_q <= 1'b1;
			if (st_q == ST_ADDR)
				ack_seen_q <= 1'b0;
			else if (in_data_w && ack_w)
				ack_seen_q <= 1'b1;
		end
	end

	// Auxiliary strobes
	wire xfer_w  = in_data_w | (st_q == ST_GAP);
	wire io_on_w = (~wr_x_q & ctrl_q.io_rd) | (wr_x_q & ctrl_q.io_wr);
	wire mem_w   = (~wr_x_q & ctrl_q.mem_rd) | (wr_x_q & ctrl_q.mem_wr);
	wire ext_w   = (~rd_n & ctrl_q.ext_rd) | (~wr_n & ctrl_q.ext_wr);
	// Drop with the read strobe, not one cycle after it
	wire fin_w   = rise_w & in_data_w & done_w & (left_q == 5'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_drive_enable_n      <= 1'b1;
			memory_pulse_n          <= 1'b1;
			io_pulse_n              <= 1'b1;
			extended_drive_enable_n <= 1'b1;
			pin3_oe_n               <= 1'b1;
			pin2_oe_n               <= 1'b1;
		end else begin
			mem_drive_enable_n <= ~(xfer_w & ~wr_x_q & ad_oe_n & ~fin_w);
			memory_pulse_n     <= ~(in_data_w & mem_w & ~capd_q);
			io_pulse_n         <= ~(xfer_w & io_on_w);
			if (ext_w)
				extended_drive_enable_n <= 1'b0;
			else if (fall_w)
				extended_drive_enable_n <= 1'b1;
			pin3_oe_n <= ~ctrl_q.pin3_io | bus_oe_n;
			pin2_oe_n <= ~ctrl_q.pin2_ext | bus_oe_n;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	addr_phase_a: assert property (ale |-> (!ad_oe_n &&
		ad_out[31:4] == addr_q[31:4]))
		else $error("address phase lacks the address");
	be_mask_a: assert property (ale && !rd_n && ctrl_q.be_rdmask
		|-> ad_out[3:0] == 4'hf)
		else $error("lane strobes active on masked read");
	drive_order_a: assert property ($fell(mem_drive_enable_n)
		|-> $past(ad_oe_n) && !rd_n)
		else $error("memory enable before bus release");
	no_wr_drive_a: assert property (!wr_n |-> mem_drive_enable_n)
		else $error("memory enable during write");
	burst_miss_a: assert property (ale && !rd_n && !burst_near_n
		|-> diag)
		else $error("block read without cache miss");
	grant_float_a: assert property (!master_grant_n
		|-> bus_oe_n && ad_oe_n)
		else $error("bus driven while granted");
	reclaim_wait_a: assert property (st_q == ST_IDLE &&
		$past(st_q) == ST_RECLAIM |-> $past(s2_q.req_n))
		else $error("reclaim ended with request held");
	block_zero_a: assert property ($rose(ale) && !rd_n && !burst_near_n
		|-> addr_lo == 4'h0)
		else $error("block read not starting at zero");
	lo_step_a: assert property (st_q == ST_GAP && $past(st_q) == ST_DATA
		|-> addr_lo == 4'($past(addr_lo) + pb_w[3:0]))
		else $error("low address step wrong");
	ext_hold_a: assert property ($rose(extended_drive_enable_n)
		|-> rd_n && wr_n && $past(fall_w))
		else $error("extended enable released early");
	mem_pulse_a: assert property (!memory_pulse_n
		|-> $past(st_q) == ST_DATA)
		else $error("memory strobe outside data phase");
	write_done_c: cover property (st_q == ST_TURN && wr_x_q);
	block_read_c: cover property (take_w && !burst_near_n && left_q == 5'h0);
	reclaim_c:    cover property (st_q == ST_RECLAIM ##1 st_q == ST_IDLE);

endmodule

`default_nettype wire

// >>> verilog/mcbus_defs.svh
`ifndef MCBUS_DEFS_SVH
`define MCBUS_DEFS_SVH

// Register byte offsets
`define OFF_CTRL   12'h000
`define OFF_ADDR   12'h004
`define OFF_WDATA  12'h008
`define OFF_CMD    12'h00c
`define OFF_STATUS 12'h010
`define OFF_RDATA0 12'h014
`define OFF_RDATA3 12'h020

// Field widths and positions
`define CTRL_W     14
`define CMD_W      9
`define CMD_LO_HI  3
`define CMD_WR_BIT 4
`define CMD_SZ_LO  5
`define CMD_SZ_HI  6

// Reset values
`define CTRL_RST   14'h0000
`define CMD_RST    9'h000

// Port width codes
`define PW_32      2'h0
`define PW_16      2'h1
`define PW_8       2'h2

// Data per four-word block, in bytes
`define BLOCK_BYTES 5'h10

`endif

// >>> verilog/mcbus_pkg.sv
`default_nettype none
package mcbus_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_GAP,
		ST_TURN,
		ST_GRANT,
		ST_RECLAIM
	} bus_state_e;

	typedef enum logic [1:0] {
		SZ_BYTE,
		SZ_HALF,
		SZ_WORD,
		SZ_QUAD
	} size_e;

	typedef struct packed {
		logic [1:0] port_w;
		logic       mem_wr;
		logic       mem_rd;
		logic       ext_wr;
		logic       ext_rd;
		logic       io_wr;
		logic       io_rd;
		logic       pin2_ext;
		logic       pin3_io;
		logic       reclaim;
		logic       early_gnt;
		logic       dburst;
		logic       be_rdmask;
	} ctrl_s;

	typedef struct packed {
		logic       instr;
		logic       miss;
		size_e      size;
		logic       write;
		logic [3:0] lo;
	} cmd_s;

	typedef struct packed {
		logic clk;
		logic ack_n;
		logic cap_n;
		logic req_n;
		logic c3;
		logic c2;
	} pins_s;

endpackage
`default_nettype wire

// >>> dv/mem_partner.sv
`timescale 1ns/10ps
`default_nettype none

module mem_partner (
	input  wire logic        link_clk,
	input  wire logic        slow,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        mem_drive_enable_n,
	input  wire logic [3:0]  addr_lo,
	input  wire logic [31:0] ad_out,
	output logic      [31:0] ad_in,
	output logic             ack_n,
	output logic             read_capture_enable_n,
	output logic      [31:0] lo_log,
	output logic      [31:0] wr_log
);
	logic [3:0] cnt;
	logic       skip;
	logic       go;

	assign go = !(slow && skip);

	initial begin
		ad_in = 32'h0;
		ack_n = 1'b1;
		read_capture_enable_n = 1'b1;
		cnt = 4'h0;
		skip = 1'b0;
		lo_log = 32'h0;
		wr_log = 32'h0;
	end

	// Acts half a link cycle before the device samples
	always @(negedge link_clk) begin
		skip <= !skip;
		ad_in <= ~ad_in; // Undriven bus never holds stale data
		if (ale) begin
			cnt <= 4'h0;
			lo_log <= 32'h0;
			wr_log <= 32'h0;
		end
		if (!ack_n) begin
			ack_n <= 1'b1;
			read_capture_enable_n <= 1'b1;
		end else if (!wr_n && !ale && go) begin
			ack_n <= 1'b0;
			lo_log <= {lo_log[27:0], addr_lo};
			wr_log <= {wr_log[23:0], ad_out[7:0]};
		end else if (!rd_n && !mem_drive_enable_n && go) begin
			ack_n <= 1'b0;
			read_capture_enable_n <= 1'b0;
			ad_in <= {8{cnt}};
			cnt <= cnt + 4'h1;
			lo_log <= {lo_log[27:0], addr_lo};
		end
	end
endmodule

`default_nettype wire

// >>> dv/test_multiplexed_cpu_bus_interface.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcbus_defs.svh"

module test_multiplexed_cpu_bus_interface;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ad_in, ad_out, lo_log, wr_log, adr_q, q;
	logic        link_clk, ad_oe_n, bus_oe_n, ale, diag, rd_n, wr_n;
	logic [3:0]  addr_lo;
	logic        burst_near_n, mem_drive_enable_n, ack_n, slow, e;
	logic        read_capture_enable_n, master_request_n, master_grant_n;
	logic        pin3_in, io_pulse_n, pin3_oe_n, pin2_in, p3, p2;
	logic        extended_drive_enable_n, pin2_oe_n, memory_pulse_n;
	logic        near_q, diag_q, mp_q, io_q, ex_q;
	int          pulses, iops, num_errors, compares, p0, i0, exts, x0;

	// Pins read back what the device drives when it owns them
	assign pin3_in = pin3_oe_n ? p3 : io_pulse_n;
	assign pin2_in = pin2_oe_n ? p2 : extended_drive_enable_n;

	mcbus_unit mcbus_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.system_reference_clock(link_clk), .ad_in(ad_in), .ad_out(ad_out),
		.ad_oe_n(ad_oe_n), .bus_oe_n(bus_oe_n), .ale(ale),
		.addr_lo(addr_lo), .diag(diag), .rd_n(rd_n), .wr_n(wr_n),
		.burst_near_n(burst_near_n), .mem_drive_enable_n(mem_drive_enable_n),
		.ack_n(ack_n), .read_capture_enable_n(read_capture_enable_n),
		.master_request_n(master_request_n), .master_grant_n(master_grant_n),
		.pin3_in(pin3_in), .io_pulse_n(io_pulse_n), .pin3_oe_n(pin3_oe_n),
		.pin2_in(pin2_in), .extended_drive_enable_n(extended_drive_enable_n),
		.pin2_oe_n(pin2_oe_n), .memory_pulse_n(memory_pulse_n));

	mem_partner mem_partner_i (.link_clk(link_clk), .slow(slow), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n), .mem_drive_enable_n(mem_drive_enable_n),
		.addr_lo(addr_lo), .ad_out(ad_out), .ad_in(ad_in), .ack_n(ack_n),
		.read_capture_enable_n(read_capture_enable_n), .lo_log(lo_log),
		.wr_log(wr_log));

	always #25 pclk = ~pclk;
	always #200 link_clk = ~link_clk;

	always @(posedge pclk) begin
		if (ale) begin
			adr_q <= ad_out;
			near_q <= burst_near_n;
			diag_q <= diag;
		end
		mp_q <= memory_pulse_n;
		io_q <= io_pulse_n;
		ex_q <= extended_drive_enable_n;
		if (ex_q && !extended_drive_enable_n)
			exts <= exts + 1;
		if (mp_q && !memory_pulse_n)
			pulses <= pulses + 1;
		if (io_q && !io_pulse_n)
			iops <= iops + 1;
		if (io_q && !io_pulse_n && ale) begin
			num_errors++;
			$display("Error at %0t: io pulse in address phase", $time);
		end
		if (presetn && !mem_drive_enable_n && (!ad_oe_n || rd_n)) begin
			num_errors++;
			$display("Error at %0t: memory enabled while bus driven", $time);
		end
	end

	task automatic test_done();
		$display("Checks: %0d compares, %0d errors", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 50) begin
			num_errors++;
			$display("Error at %0t: no pready", $time);
			test_done();
		end
	endtask

	// Polls status until (status & m) == v matches eq
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v,
			input logic eq);
		int n;
		n = 0;
		do begin
			apb(1'b0, `OFF_STATUS, 32'h0);
			n++;
		end while ((((q & m) === v) != eq) && n < 3000);
		if (n >= 3000) begin
			num_errors++;
			$display("Error at %0t: status wait timed out", $time);
			test_done();
		end
	endtask

	task automatic xact(input logic [31:0] a, input logic [31:0] cmd);
		apb(1'b1, `OFF_ADDR, a);
		p0 = pulses;
		i0 = iops;
		x0 = exts;
		apb(1'b1, `OFF_CMD, cmd);
		wait_st(32'h7, 32'h0, 1'b0);
		wait_st(32'h7, 32'h0, 1'b1);
	endtask

	task automatic t_reset();
		chk({rd_n, wr_n, master_grant_n, ale}, 4'he, "idle pins");
		apb(1'b0, `OFF_CTRL, 32'h0);
		chk(q, 32'h0, "ctrl reset");
		apb(1'b0, 12'h024, 32'h0);
		chk(e, 1'b1, "unmapped error");
		chk(q, 32'h0, "unmapped data");
	endtask

	task automatic t_write32();
		apb(1'b1, `OFF_CTRL, 32'h0eb0);
		apb(1'b1, `OFF_WDATA, 32'hcafef00d);
		xact(32'h12345670, 32'h050);
		chk(adr_q[31:4], 28'h1234567, "addr high");
		chk(adr_q[3:0], 4'h0, "word lanes");
		chk(wr_log[7:0], 8'h0d, "store data");
		chk(pulses - p0, 1, "mem pulses");
		chk(iops - i0, 1, "io pulses");
		chk(exts - x0, 1, "ext pulses");
		chk(extended_drive_enable_n, 1'b1, "ext released");
		xact(32'h12345680, 32'h016);
		chk({adr_q[3:0], near_q}, 5'h16, "byte lane near");
		chk(lo_log[3:0], 4'h6, "byte addr");
		xact(32'h12346680, 32'h016);
		chk(near_q, 1'b1, "far page");
	endtask

	task automatic t_narrow();
		slow <= 1'b1;
		apb(1'b1, `OFF_CTRL, 32'h2c00);
		apb(1'b1, `OFF_WDATA, 32'h44332211);
		xact(32'h00000400, 32'h054);
		chk(lo_log[15:0], 16'h4567, "byte steps");
		chk(wr_log, 32'h11223344, "byte data");
		chk(pulses - p0, 4, "pulses");
		slow <= 1'b0;
	endtask

	task automatic t_reads();
		apb(1'b1, `OFF_CTRL, 32'h1c00);
		xact(32'h00001000, 32'h1e0);
		chk({near_q, diag_q}, 2'b01, "block flags");
		chk(lo_log, 32'h02468ace, "block count");
		chk(pulses - p0, 8, "pulses");
		for (int j = 0; j < 4; j++) begin
			apb(1'b0, 12'(`OFF_RDATA0 + 4 * j), 32'h0);
			chk(q, {{4{4'(2 * j + 1)}}, {4{4'(2 * j)}}}, "rbuf");
		end
		apb(1'b1, `OFF_CTRL, 32'h0c01);
		xact(32'h00002000, 32'h0c8);
		chk({adr_q[3:0], near_q, diag_q}, 6'h3f, "masked");
		chk(lo_log[3:0], 4'h8, "single addr");
		apb(1'b0, 12'h01c, 32'h0);
		chk(q, 32'h0, "single word");
		xact(32'h00003000, 32'h0e0);
		chk(near_q, 1'b1, "data miss single");
		apb(1'b1, `OFF_CTRL, 32'h0c02);
		xact(32'h00003000, 32'h0e0);
		chk(near_q, 1'b0, "data miss block");
		chk(lo_log[15:0], 16'h048c, "wide block count");
		chk(pulses - p0, 4, "wide pulses");
		apb(1'b0, `OFF_RDATA3, 32'h0);
		chk(q, 32'h33333333, "wide capture");
	endtask

	task automatic t_grant();
		apb(1'b1, `OFF_CTRL, 32'h0004);
		master_request_n <= 1'b0;
		wait_st(32'h200, 32'h200, 1'b1);
		chk({master_grant_n, bus_oe_n}, 2'b01, "granted");
		master_request_n <= 1'b1;
		wait_st(32'h7, 32'h0, 1'b1);
		chk({master_grant_n, bus_oe_n}, 2'b10, "returned");
		master_request_n <= 1'b0;
		wait_st(32'h200, 32'h200, 1'b1);
		apb(1'b1, `OFF_CTRL, 32'h000c);
		wait_st(32'h7, 32'h6, 1'b1);
		chk(master_grant_n, 1'b1, "reclaim");
		master_request_n <= 1'b1;
		wait_st(32'h7, 32'h0, 1'b1);
		chk(bus_oe_n, 1'b0, "bus back");
	endtask

	task automatic t_cond();
		apb(1'b1, `OFF_CTRL, 32'h0);
		p3 <= 1'b1;
		wait_st(32'hc00, 32'h800, 1'b1);
		chk({pin3_oe_n, pin2_oe_n}, 2'b11, "pins input");
		p3 <= 1'b0;
		p2 <= 1'b1;
		wait_st(32'hc00, 32'h400, 1'b1);
		chk(q[11:10], 2'b01, "cond bits");
	endtask

	initial begin
		{pclk, link_clk, presetn, psel, penable, pwrite, slow, p3, p2} = 9'h0;
		{paddr, pwdata, pulses, iops, exts, num_errors, compares} = '0;
		master_request_n = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_write32();
		t_narrow();
		t_reads();
		t_grant();
		t_cond();
		test_done();
	end
endmodule

`default_nettype wire
